// ===== logic/acs_pkg.sv
// package: shared constants and types for the converter sequencing block
package acs_pkg;
   localparam int ACS_CONV_CLOCKS = 16;     // shift clocks per conversion
   localparam int ACS_CNT_W = 4;            // width of the edge counter
   localparam int ACS_TRACK_CLOCKS = 3;     // track phase length
   localparam int ACS_ZERO_EDGES = 4;       // leading zero falling edges
   localparam int ACS_CTRL_EDGES = 8;       // control byte rising edges
   localparam int ACS_RES_W = 12;           // result width
   localparam int ACS_CH_W = 3;             // channel select width
   localparam int ACS_CH_MSB_POS = 5;       // channel field top bit in control byte
   localparam logic [2:0] ACS_CH_RESET = 3'h0;
   localparam logic [3:0] ACS_CNT_RESET = 4'h0;
   // conversion phase, one-hot
   typedef enum logic [3:0] {
      ACS_OFF   = 4'b0001,
      ACS_TRACK = 4'b0010,
      ACS_HOLD  = 4'b0100,
      ACS_GAP   = 4'b1000
   } acs_phase_t;
endpackage

// ===== logic/acs_sync.sv
// two-flop synchroniser for pin inputs
module acs_sync
   import acs_pkg::*;
#(
   parameter logic RESET_VAL = 1'b0
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic q
);
   logic meta;

   // ===================================================
   // first flop only feeds the second
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta <= RESET_VAL;
         q <= RESET_VAL;
      end
      else
      begin
         meta <= pin;
         q <= meta;
      end
   end
endmodule // acs_sync

// ===== logic/acs_seq.sv
// sequencing and power control of the serial converter
module acs_seq
   import acs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic frame_sel_n,
   input wire logic shift_clk,
   input wire logic data_in,
   input wire logic [ACS_RES_W-1:0] sample_result,
   output logic data_out,
   output logic data_out_oe,
   output logic powered,
   output logic tracking,
   output logic converting,
   output logic [ACS_CH_W-1:0] track_channel,
   output logic [ACS_CH_W-1:0] next_channel_sel,
   output logic conv_done
);
   logic cs_n_s;
   logic sck_s;
   logic din_s;
   logic sck_d;
   logic cs_d;
   logic [ACS_CNT_W-1:0] rise_cnt;
   logic [ACS_CNT_W-1:0] fall_cnt;
   logic [7:0] ctrl_sr;
   logic [ACS_RES_W-1:0] shift_res;
   logic [ACS_RES_W-1:0] res_s;
   acs_phase_t phase;
   acs_phase_t next_phase;

   // ===================================================
   // pin synchronisers
   acs_sync #(.RESET_VAL(1'b1)) u_cs (.clk(clk), .rst_n(rst_n), .pin(frame_sel_n), .q(cs_n_s));
   acs_sync #(.RESET_VAL(1'b0)) u_sck (.clk(clk), .rst_n(rst_n), .pin(shift_clk), .q(sck_s));
   acs_sync #(.RESET_VAL(1'b0)) u_din (.clk(clk), .rst_n(rst_n), .pin(data_in), .q(din_s));

   // ===================================================
   // result word synchronised bit by bit; it is only captured at the fourth
   // falling edge, long after it settled, so its bits never resolve apart there
   genvar b;
   generate
      for (b = 0; b < ACS_RES_W; b = b + 1)
      begin : g_res_sync
         acs_sync #(.RESET_VAL(1'b0)) u_res (.clk(clk), .rst_n(rst_n),
            .pin(sample_result[b]), .q(res_s[b]));
      end
   endgenerate

   // ===================================================
   // edge decode; shift clock gated off while deselected
   wire active = !cs_n_s;
   wire cs_fall = active && cs_d;
   wire cs_rise = cs_n_s && !cs_d;
   wire sck_rise = active && sck_s && !sck_d;
   wire sck_fall_raw = active && !sck_s && sck_d;
   // frame start with clock low counts as the first falling edge
   wire sck_fall = sck_fall_raw || (cs_fall && !sck_s);
   wire last_fall = sck_fall && (fall_cnt == 4'(ACS_CONV_CLOCKS - 1));
   wire first_fall = sck_fall && (fall_cnt == ACS_CNT_RESET);
   wire hold_fall = sck_fall && (fall_cnt == 4'(ACS_TRACK_CLOCKS));
   wire ctrl_last = sck_rise && (rise_cnt == 4'(ACS_CTRL_EDGES - 1));
   wire [7:0] ctrl_byte = {ctrl_sr[6:0], din_s};
   wire zero_phase = fall_cnt < 4'(ACS_ZERO_EDGES);

   // ===================================================
   // phase transitions
   always_comb
   begin
      next_phase = phase;
      case (phase)
         ACS_OFF: if (first_fall) next_phase = ACS_TRACK;
         ACS_TRACK: if (hold_fall) next_phase = ACS_HOLD;
         ACS_HOLD: if (last_fall) next_phase = ACS_GAP;
         ACS_GAP: if (first_fall) next_phase = ACS_TRACK;
         default: next_phase = ACS_OFF;
      endcase
      if (!active) next_phase = ACS_OFF;
   end

   // ===================================================
   // sequencing state; counters restart every frame
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         phase <= ACS_OFF;
         sck_d <= 1'b0;
         cs_d <= 1'b1;
         rise_cnt <= ACS_CNT_RESET;
         fall_cnt <= ACS_CNT_RESET;
         ctrl_sr <= 8'h00;
         shift_res <= '0;
         next_channel_sel <= ACS_CH_RESET;
         track_channel <= ACS_CH_RESET;
         data_out <= 1'b0;
         data_out_oe <= 1'b0;
         powered <= 1'b0;
         tracking <= 1'b0;
         converting <= 1'b0;
         conv_done <= 1'b0;
      end
      else
      begin
         sck_d <= sck_s;
         cs_d <= cs_n_s;
         phase <= next_phase;
         powered <= (next_phase == ACS_TRACK) || (next_phase == ACS_HOLD);
         tracking <= next_phase == ACS_TRACK;
         converting <= next_phase == ACS_HOLD;
         conv_done <= last_fall && active;
         data_out_oe <= active;
         if (!active)
         begin
            rise_cnt <= ACS_CNT_RESET;
            fall_cnt <= ACS_CNT_RESET;
            data_out <= 1'b0;
         end
         else
         begin
            // 4-bit counters wrap at 16, marking each conversion slot
            if (sck_rise) rise_cnt <= rise_cnt + 4'h1;
            if (sck_fall) fall_cnt <= fall_cnt + 4'h1;
            if (sck_rise && (rise_cnt < 4'(ACS_CTRL_EDGES))) ctrl_sr <= ctrl_byte;
            if (ctrl_last)
               next_channel_sel <= ctrl_byte[ACS_CH_MSB_POS -: ACS_CH_W];
            if (first_fall)
               track_channel <= next_channel_sel;
            if (hold_fall)
               shift_res <= res_s;
            // zeros first, then result msb first
            // only the held word is shifted, so a moving input cannot tear the result
            if (sck_fall)
            begin
               if (zero_phase || first_fall) data_out <= 1'b0;
               else data_out <= shift_res[ACS_RES_W - 1 - (fall_cnt - 4'(ACS_ZERO_EDGES))];
            end
         end
      end
   end

   // ===================================================
   // checks
   property p_off_when_deselected;
      @(posedge clk) disable iff (!rst_n) cs_n_s |=> !powered && !data_out_oe;
   endproperty
   a_off_when_deselected: assert property (p_off_when_deselected) else $error("not off");

   property p_gap_after_last;
      @(posedge clk) disable iff (!rst_n) (last_fall && active && !cs_rise) |=> !powered;
   endproperty
   a_gap_after_last: assert property (p_gap_after_last) else $error("no gap");

   property p_track_on_first;
      @(posedge clk) disable iff (!rst_n) (first_fall && active) |=> tracking;
   endproperty
   a_track_on_first: assert property (p_track_on_first) else $error("no track");

   property p_hold_on_fourth;
      @(posedge clk) disable iff (!rst_n) (hold_fall && phase == ACS_TRACK) |=> converting;
   endproperty
   a_hold_on_fourth: assert property (p_hold_on_fourth) else $error("no hold");

   property p_zero_lead;
      @(posedge clk) disable iff (!rst_n) (sck_fall && zero_phase && active) |=> !data_out;
   endproperty
   a_zero_lead: assert property (p_zero_lead) else $error("lead not zero");

   property p_chan_load;
      @(posedge clk) disable iff (!rst_n)
         (ctrl_last && active) |=> next_channel_sel == $past(ctrl_byte[5:3]);
   endproperty
   a_chan_load: assert property (p_chan_load) else $error("bad channel");

   property p_done_pulse;
      @(posedge clk) disable iff (!rst_n) conv_done |=> !conv_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done too long");

   property p_counter_clear;
      @(posedge clk) disable iff (!rst_n) cs_n_s |=> fall_cnt == 4'h0 && rise_cnt == 4'h0;
   endproperty
   a_counter_clear: assert property (p_counter_clear) else $error("count kept");

   // ===================================================
   // capture, framing and output checks
   property p_capture_at_hold;
      @(posedge clk) disable iff (!rst_n) (hold_fall && active) |=> shift_res == $past(res_s);
   endproperty
   a_capture_at_hold: assert property (p_capture_at_hold) else $error("no capture");

   property p_done_on_last;
      @(posedge clk) disable iff (!rst_n) (last_fall && phase == ACS_HOLD) |=> conv_done;
   endproperty
   a_done_on_last: assert property (p_done_on_last) else $error("no done");

   property p_oe_while_selected;
      @(posedge clk) disable iff (!rst_n) active |=> data_out_oe;
   endproperty
   a_oe_while_selected: assert property (p_oe_while_selected) else $error("not driving");

   property p_result_msb;
      @(posedge clk) disable iff (!rst_n)
         (sck_fall && fall_cnt == 4'(ACS_ZERO_EDGES)) |=> data_out == shift_res[ACS_RES_W-1];
   endproperty
   a_result_msb: assert property (p_result_msb) else $error("msb not first");

   property p_idle_ignores_clock;
      @(posedge clk) disable iff (!rst_n) cs_n_s |=> !conv_done && phase == ACS_OFF;
   endproperty
   a_idle_ignores_clock: assert property (p_idle_ignores_clock) else $error("clock seen");
endmodule // acs_seq

// ===== verif/acs_host_model.sv
// host controller model that frames conversions on the serial pins
module acs_host_model
   import acs_pkg::*;
(
   output logic frame_sel_n,
   output logic shift_clk,
   output logic data_in,
   output logic [ACS_RES_W-1:0] sample_result,
   input wire logic data_out,
   input wire logic tracking,
   input wire logic converting,
   input wire logic powered
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] words[$];
   logic [7:0] ctrls[$];
   logic [3:0] phases[$];
   logic [ACS_RES_W-1:0] samples[$];
   // ==========================================
   // idle pins: clock parks high between frames
   initial
   begin
      frame_sel_n = 1'b1;
      shift_clk = 1'b1;
      data_in = 1'b0;
      sample_result = '0;
   end
   // n conversions in one frame; lim below 16 cuts the frame short
   // low_start parks the clock low first, so the frame edge is the first fall
   task automatic run(input int n, input int lim, input bit low_start);
      logic [7:0] c;
      logic [15:0] w;
      logic t1;
      if (low_start)
         #24 shift_clk = 1'b0;
      #1.3 frame_sel_n = 1'b0;
      #24;
      for (int i = 0; i < n; i++)
      begin
         c = 8'($urandom);
         sample_result = ACS_RES_W'($urandom); // moves long before the 4th fall
         for (int k = 0; k < lim; k++)
         begin
            shift_clk = 1'b0;
            data_in = (k < 8) ? c[7 - k] : ~data_in;
            #24 shift_clk = 1'b1;
            w = {w[14:0], data_out};
            if (k == 1)
               t1 = tracking;
            if (k == 4)
               phases.push_back({t1, tracking, converting, powered});
            #24;
         end
         if (lim == 16)
         begin
            words.push_back(w);
            ctrls.push_back(c);
            samples.push_back(sample_result);
         end
      end
      frame_sel_n = 1'b1;
      data_in = ~data_in; // released line must not look held
      #120;
   endtask
   // clock keeps toggling while deselected
   task automatic idle_clocks(input int n);
      repeat (2 * n) #24 shift_clk = ~shift_clk;
   endtask
endmodule // acs_host_model

// ===== verif/tb_top.sv
// self-checking bench for the converter sequencing block
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import acs_pkg::*;
   logic clk, rst_n, frame_sel_n, shift_clk, data_in, data_out, data_out_oe;
   logic powered, tracking, converting, conv_done;
   logic [ACS_RES_W-1:0] sample_result;
   logic [ACS_CH_W-1:0] track_channel, next_channel_sel, exp_ch;
   logic [ACS_CH_W-1:0] chans[$], nexts[$];
   logic pows[$], oes[$];
   logic [7:0] c;
   int errors, tests_run, dones, i;
   acs_seq u_dut (.clk(clk), .rst_n(rst_n), .frame_sel_n(frame_sel_n),
      .shift_clk(shift_clk), .data_in(data_in), .sample_result(sample_result),
      .data_out(data_out), .data_out_oe(data_out_oe), .powered(powered),
      .tracking(tracking), .converting(converting), .track_channel(track_channel),
      .next_channel_sel(next_channel_sel), .conv_done(conv_done));
   acs_host_model u_host (.frame_sel_n(frame_sel_n), .shift_clk(shift_clk),
      .data_in(data_in), .sample_result(sample_result), .data_out(data_out),
      .tracking(tracking), .converting(converting), .powered(powered));
   // ==========================================
   // clock and watchdog
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      #60us;
      errors++;
      conclude();
   end
   // record channel and power state at each finished conversion
   always @(posedge clk)
      if (conv_done === 1'b1)
      begin
         dones++;
         chans.push_back(track_channel);
         nexts.push_back(next_channel_sel);
         oes.push_back(data_out_oe);
         repeat (2) @(posedge clk);
         pows.push_back(powered);
      end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // main sequence; channel expectation lags one conversion
   initial
   begin
      rst_n = 1'b0;
      exp_ch = ACS_CH_RESET;
      void'($urandom(32'h4c18));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      repeat (3) u_host.run(1, 16, 1'b0);
      u_host.run(4, 16, 1'b0);
      u_host.run(1, 2, 1'b0);
      cmp(data_out_oe, 1'b0);
      cmp(powered, 1'b0);
      i = dones;
      u_host.idle_clocks(32);
      cmp(dones, i);
      #500;
      u_host.run(2, 16, 1'b0);
      u_host.run(2, 16, 1'b1);
      #200;
      cmp(dones, 11);
      while (u_host.words.size() > 0)
      begin
         cmp(u_host.words.pop_front(), {4'h0, u_host.samples.pop_front()});
         cmp(chans.pop_front(), exp_ch);
         c = u_host.ctrls.pop_front();
         exp_ch = c[5:3];
         cmp(nexts.pop_front(), c[5:3]);
         cmp(oes.pop_front(), 1'b1);
         cmp(pows.pop_front(), 1'b0);
         cmp(u_host.phases.pop_front(), 4'b1011);
      end
      conclude();
   end
endmodule // tb_top
